/* design/afsut_core.sv */
// The plain strobed port was decided locally.
`timescale 1ns/10ps
module afsut_core
	import afsut_pkg::*;
#(
	parameter int          POS_W         = 12,
	parameter logic [63:0] FRAC_FMT_MASK = 64'h0000_0000_0000_00aa
) (
	input  wire logic              mclk,
	input  wire logic              sys_rst,
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic [DATA_W-1:0]      reg_rdata,
	input  wire logic [5:0]        video_format_select,
	input  wire logic [2:0]        audio_rate_select,
	input  wire logic              hsync_lead,
	input  wire logic              vsync_lead,
	input  wire logic              frame_start,
	input  wire logic              ten_field_ref,
	output logic                   audio_frame_pulse,
	output logic                   aclk_div_restart,
	output logic [3:0]             user_out
);
	generate
		if (POS_W < 2 || POS_W > DATA_W) begin : g_bad
			$error("POS_W out of range");
		end
	endgenerate

	typedef struct packed {
		logic                  realign_dis;
		logic                  host_fmt;
		logic [5:0]            fmt;
		logic [2:0]            rate;
		logic [4:0]            pol;
		logic [7:0]            cmb;
		logic [15:0][POS_W-1:0] ut;
		logic                  pend;
		logic [6:0]            fcnt;
		logic                  afp_act;
		logic                  afp_pin;
		logic                  restart;
		logic [POS_W-1:0]      hcnt;
		logic [POS_W-1:0]      vcnt;
		logic [3:0]            upin;
		logic [DATA_W-1:0]     rdata;
	} afsut_state_t;

	afsut_state_t st_reg;
	afsut_state_t st_next;

	function automatic logic [6:0] afsut_period(input logic frac, input logic [2:0] rate);
		if (!frac) begin
			return N_INTEGER;
		end
		unique case (rate)
			RATE_48K, RATE_96K, RATE_24K:     return N_FRAC_48;
			RATE_44K1, RATE_88K2, RATE_22K05: return N_FRAC_441;
			RATE_32K:                         return N_FRAC_32;
			default:                          return N_INTEGER;
		endcase
	endfunction

	function automatic logic afsut_window(input logic [POS_W-1:0] pos,
		input logic [POS_W-1:0] start, input logic [POS_W-1:0] stop);
		return (pos >= start) && (pos < stop);
	endfunction

	logic [5:0] fmt_sel;
	logic [2:0] rate_sel;
	logic [6:0] n_cur;
	logic       ref_take;
	logic       host_rst;
	logic       pulse_frame;

	assign fmt_sel  = st_reg.host_fmt ? st_reg.fmt : video_format_select;
	assign rate_sel = st_reg.host_fmt ? st_reg.rate : audio_rate_select;
	assign n_cur    = afsut_period(FRAC_FMT_MASK[fmt_sel], rate_sel);
	assign ref_take = ten_field_ref && !st_reg.realign_dis;
	assign host_rst = reg_wr && reg_addr == OFS_DIV_RESET && reg_wdata[BIT_DIV_RESET];
	assign pulse_frame = frame_start && (st_reg.pend || ref_take || st_reg.fcnt == n_cur - 7'h01);

	always_comb begin
		logic [1:0] f;
		logic       hp;
		logic       vp;
		logic       c;
		f = 2'h0;
		hp = 1'b0;
		vp = 1'b0;
		c = 1'b0;
		st_next = st_reg;
		st_next.restart = 1'b0;
		// Register writes
		if (reg_wr) begin
			if (reg_addr == OFS_AUDIO_CTL) begin
				st_next.realign_dis = reg_wdata[BIT_REALIGN_DIS];
				st_next.host_fmt = reg_wdata[BIT_HOST_FMT];
			end
			if (reg_addr == OFS_FMT_SEL) begin
				st_next.fmt = reg_wdata[FLD_FMT_LSB +: 6];
				st_next.rate = reg_wdata[FLD_RATE_LSB +: 3];
			end
			if (reg_addr == OFS_POLARITY) begin
				st_next.pol = reg_wdata[4:0];
			end
			if (reg_addr == OFS_COMBINE) begin
				st_next.cmb = reg_wdata[7:0];
			end
			for (int i = 0; i < 16; i++) begin
				if (reg_addr == OFS_USER_BASE + 8'(i)) begin
					st_next.ut[i] = reg_wdata[POS_W-1:0];
				end
			end
		end
		// Frame divider
		if (pulse_frame) begin
			st_next.fcnt = 7'h00;
			st_next.afp_act = 1'b1;
			st_next.restart = 1'b1;
		end else if (frame_start) begin
			st_next.fcnt = (st_reg.fcnt >= n_cur - 7'h01) ? 7'h00 : st_reg.fcnt + 7'h01;
			st_next.afp_act = 1'b0;
		end else if (hsync_lead) begin
			st_next.afp_act = 1'b0;
		end
		// Pending realignment: a new host reset wins over consumption
		if (frame_start) begin
			st_next.pend = 1'b0;
		end
		if ((ref_take || host_rst) && !frame_start) begin
			st_next.pend = 1'b1;
		end
		if (host_rst && frame_start) begin
			st_next.pend = 1'b1;
		end
		st_next.afp_pin = st_next.afp_act ^ st_reg.pol[BIT_POL_AFP];
		// Pixel and line counters
		if (hsync_lead) begin
			st_next.hcnt = '0;
		end else if (st_reg.hcnt != '1) begin
			st_next.hcnt = st_reg.hcnt + POS_W'(1);
		end
		if (vsync_lead) begin
			st_next.vcnt = '0;
		end else if (hsync_lead && st_reg.vcnt != '1) begin
			st_next.vcnt = st_reg.vcnt + POS_W'(1);
		end
		// User outputs
		for (int i = 0; i < 4; i++) begin
			hp = afsut_window(st_reg.hcnt, st_reg.ut[4*i], st_reg.ut[4*i+1]);
			vp = afsut_window(st_reg.vcnt, st_reg.ut[4*i+2], st_reg.ut[4*i+3]);
			f = st_reg.cmb[2*i +: 2];
			unique case (f)
				CMB_OR:  c = hp | vp;
				CMB_XOR: c = hp ^ vp;
				default: c = hp & vp;
			endcase
			st_next.upin[i] = c ^ st_reg.pol[BIT_POL_USER + i];
		end
		// Read data
		st_next.rdata = '0;
		if (reg_rd) begin
			unique case (reg_addr)
				OFS_AUDIO_CTL: begin
					st_next.rdata[BIT_REALIGN_DIS] = st_reg.realign_dis;
					st_next.rdata[BIT_HOST_FMT] = st_reg.host_fmt;
				end
				OFS_FMT_SEL: begin
					st_next.rdata[FLD_FMT_LSB +: 6] = st_reg.fmt;
					st_next.rdata[FLD_RATE_LSB +: 3] = st_reg.rate;
				end
				OFS_POLARITY: st_next.rdata[4:0] = st_reg.pol;
				OFS_COMBINE:  st_next.rdata[7:0] = st_reg.cmb;
				OFS_STATUS: begin
					st_next.rdata[6:0] = st_reg.fcnt;
					st_next.rdata[BIT_ST_AFP] = st_reg.afp_act;
					st_next.rdata[BIT_ST_PEND] = st_reg.pend;
				end
				default: begin
					for (int i = 0; i < 16; i++) begin
						if (reg_addr == OFS_USER_BASE + 8'(i)) begin
							st_next.rdata[POS_W-1:0] = st_reg.ut[i];
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			st_reg <= '0;
			st_reg.realign_dis <= RST_REALIGN_DIS;
			st_reg.host_fmt <= RST_HOST_FMT;
			st_reg.pol <= RST_POLARITY;
			st_reg.cmb <= RST_COMBINE;
		end else begin
			st_reg <= st_next;
		end
	end

	assign reg_rdata = st_reg.rdata;
	assign audio_frame_pulse = st_reg.afp_pin;
	assign aclk_div_restart = st_reg.restart;
	assign user_out = st_reg.upin;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	property p_afp_start;
		$rose(st_reg.afp_act) |-> $past(frame_start);
	endproperty
	a_afp_start: assert property (p_afp_start) else $error("pulse began off frame start");

	property p_afp_end;
		st_reg.afp_act && hsync_lead && !frame_start |=> !st_reg.afp_act;
	endproperty
	a_afp_end: assert property (p_afp_end) else $error("pulse outlived line one");

	property p_restart;
		aclk_div_restart |-> st_reg.afp_act && st_reg.fcnt == 7'h00 ##1 !aclk_div_restart;
	endproperty
	a_restart: assert property (p_restart) else $error("restart not with pulse frame");

	property p_period;
		frame_start |=> st_reg.fcnt < $past(n_cur);
	endproperty
	a_period: assert property (p_period) else $error("divider beyond period");

	property p_n5;
		FRAC_FMT_MASK[fmt_sel] && rate_sel == RATE_48K |-> n_cur == 7'h05;
	endproperty
	a_n5: assert property (p_n5) else $error("wrong period for 48k fractional");

	property p_realign;
		ten_field_ref && !st_reg.realign_dis && frame_start |=> st_reg.afp_act && aclk_div_restart;
	endproperty
	a_realign: assert property (p_realign) else $error("reference did not realign");

	property p_pend_cause;
		$rose(st_reg.pend) |-> $past(host_rst) || $past(ref_take);
	endproperty
	a_pend_cause: assert property (p_pend_cause) else $error("realign without cause");

	property p_host_rst;
		st_reg.pend && frame_start |=> st_reg.afp_act && aclk_div_restart && st_reg.fcnt == 7'h00;
	endproperty
	a_host_rst: assert property (p_host_rst) else $error("host reset ignored");

	property p_free;
		frame_start && !pulse_frame && !$changed(n_cur) && st_reg.fcnt < n_cur
		|=> st_reg.fcnt == $past(st_reg.fcnt) + 7'h01;
	endproperty
	a_free: assert property (p_free) else $error("divider did not advance");

	property p_pol;
		audio_frame_pulse == (st_reg.afp_act ^ $past(st_reg.pol[BIT_POL_AFP]));
	endproperty
	a_pol: assert property (p_pol) else $error("pulse polarity wrong");

	property p_hzero;
		hsync_lead ##1 !hsync_lead |=> st_reg.hcnt == POS_W'(1);
	endproperty
	a_hzero: assert property (p_hzero) else $error("pixel count not from sync");

	property p_host_pend;
		host_rst |=> st_reg.pend;
	endproperty
	a_host_pend: assert property (p_host_pend) else $error("host reset not held");

	property p_pend_clear;
		frame_start && !host_rst |=> !st_reg.pend;
	endproperty
	a_pend_clear: assert property (p_pend_clear) else $error("realign request outlived frame start");

	property p_no_realign;
		ten_field_ref && st_reg.realign_dis && frame_start && !st_reg.pend && st_reg.fcnt != n_cur - 7'h01
		|=> !st_reg.afp_act;
	endproperty
	a_no_realign: assert property (p_no_realign) else $error("disabled reference realigned");

	property p_restart_rise;
		$rose(st_reg.afp_act) |-> aclk_div_restart;
	endproperty
	a_restart_rise: assert property (p_restart_rise) else $error("pulse without divider restart");

	property p_hclr;
		hsync_lead |=> st_reg.hcnt == '0;
	endproperty
	a_hclr: assert property (p_hclr) else $error("pixel count not cleared");

	property p_vzero;
		vsync_lead |=> st_reg.vcnt == '0;
	endproperty
	a_vzero: assert property (p_vzero) else $error("line count not cleared");

	property p_vstep;
		hsync_lead && !vsync_lead && st_reg.vcnt != '1 |=> st_reg.vcnt == $past(st_reg.vcnt) + POS_W'(1);
	endproperty
	a_vstep: assert property (p_vstep) else $error("line count did not advance");

	property p_ut_hold;
		reg_wr && reg_addr == OFS_USER_BASE |=> st_reg.ut[0] == POS_W'($past(reg_wdata));
	endproperty
	a_ut_hold: assert property (p_ut_hold) else $error("timing register not written");

	property p_user_and;
		st_reg.cmb[1:0] == CMB_AND && !afsut_window(st_reg.hcnt, st_reg.ut[0], st_reg.ut[1])
		|=> user_out[0] == $past(st_reg.pol[BIT_POL_USER]);
	endproperty
	a_user_and: assert property (p_user_and) else $error("and output active off window");

	property p_user_or;
		st_reg.cmb[1:0] == CMB_OR && afsut_window(st_reg.vcnt, st_reg.ut[2], st_reg.ut[3])
		|=> user_out[0] != $past(st_reg.pol[BIT_POL_USER]);
	endproperty
	a_user_or: assert property (p_user_or) else $error("or output inactive in window");

	property p_user_xor;
		st_reg.cmb[1:0] == CMB_XOR && afsut_window(st_reg.hcnt, st_reg.ut[0], st_reg.ut[1])
		&& afsut_window(st_reg.vcnt, st_reg.ut[2], st_reg.ut[3])
		|=> user_out[0] == $past(st_reg.pol[BIT_POL_USER]);
	endproperty
	a_user_xor: assert property (p_user_xor) else $error("xor output active in both windows");

	c_pulse: cover property ($rose(audio_frame_pulse));
	c_host: cover property (host_rst ##[1:1000] aclk_div_restart);
	c_user: cover property ($rose(user_out[0]));
	c_realign: cover property (ref_take && frame_start);
	c_inverted: cover property ($fell(audio_frame_pulse) && st_reg.pol[BIT_POL_AFP]);
endmodule

/* design/afsut_pkg.sv */
package afsut_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	// Register offsets
	localparam logic [7:0] OFS_DIV_RESET = 8'h1a;
	localparam logic [7:0] OFS_AUDIO_CTL = 8'h31;
	localparam logic [7:0] OFS_FMT_SEL   = 8'h32;
	localparam logic [7:0] OFS_POLARITY  = 8'h56;
	localparam logic [7:0] OFS_USER_BASE = 8'h57;
	localparam logic [7:0] OFS_COMBINE   = 8'h67;
	localparam logic [7:0] OFS_STATUS    = 8'h68;
	// Field positions
	localparam int BIT_DIV_RESET   = 0;
	localparam int BIT_REALIGN_DIS = 0;
	localparam int BIT_HOST_FMT    = 1;
	localparam int FLD_FMT_LSB     = 0;
	localparam int FLD_RATE_LSB    = 8;
	localparam int BIT_POL_AFP     = 0;
	localparam int BIT_POL_USER    = 1;
	localparam int BIT_ST_AFP      = 8;
	localparam int BIT_ST_PEND     = 9;
	// Reset values
	localparam logic       RST_REALIGN_DIS = 1'b0;
	localparam logic       RST_HOST_FMT    = 1'b0;
	localparam logic [4:0] RST_POLARITY    = 5'h00;
	localparam logic [7:0] RST_COMBINE     = 8'h00;
	// Audio rate codes
	localparam logic [2:0] RATE_48K   = 3'h0;
	localparam logic [2:0] RATE_44K1  = 3'h1;
	localparam logic [2:0] RATE_32K   = 3'h2;
	localparam logic [2:0] RATE_96K   = 3'h3;
	localparam logic [2:0] RATE_88K2  = 3'h4;
	localparam logic [2:0] RATE_24K   = 3'h5;
	localparam logic [2:0] RATE_22K05 = 3'h6;
	// Frame periods
	localparam logic [6:0] N_INTEGER  = 7'h01;
	localparam logic [6:0] N_FRAC_48  = 7'h05;
	localparam logic [6:0] N_FRAC_441 = 7'h64;
	localparam logic [6:0] N_FRAC_32  = 7'h0f;
	// Combine functions
	localparam logic [1:0] CMB_AND = 2'h0;
	localparam logic [1:0] CMB_OR  = 2'h1;
	localparam logic [1:0] CMB_XOR = 2'h2;
endpackage

/* dv/afsut_raster.sv */
`timescale 1ns/10ps
module afsut_raster #(
	parameter int LINE_LEN = 16,
	parameter int LINES    = 6
) (
	input  wire logic mclk,
	input  wire logic sys_rst,
	input  wire logic ref_arm,
	output logic      hsync_lead,
	output logic      vsync_lead,
	output logic      frame_start,
	output logic      ten_field_ref
);
	int h;
	int v;
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			h <= 0;
			v <= 0;
		end else if (h == LINE_LEN - 1) begin
			h <= 0;
			v <= (v == LINES - 1) ? 0 : v + 1;
		end else begin
			h <= h + 1;
		end
	end
	assign hsync_lead    = !sys_rst && h == 0;
	assign frame_start   = hsync_lead && v == 0;
	assign vsync_lead    = frame_start;
	assign ten_field_ref = frame_start && ref_arm;
endmodule

/* dv/testbench.sv */
`timescale 1ns/10ps
module testbench import afsut_pkg::*; ;
	logic        mclk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [7:0]  reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [15:0] reg_rdata;
	logic [5:0]  fmt = 6'h00;
	logic [2:0]  rate = 3'h0;
	logic        ref_arm = 1'b0;
	logic        hs, vs, fs, tf, afp, rst_p;
	logic [3:0]  user_out;
	logic        rd_d = 1'b0;
	logic [15:0] exp_q[$];
	logic [15:0] d;
	logic [15:0] tbl[4] = '{16'h0006, 16'h002c, 16'h0026, 16'h0006};
	int          mismatches = 0;
	int          num_checks = 0;
	int          cyc = 0;
	int          t0, t1, i;

	always #25 mclk = ~mclk;
	always @(posedge mclk) cyc++;

	afsut_raster #(.LINE_LEN(16), .LINES(6)) far (.mclk(mclk), .sys_rst(sys_rst), .ref_arm(ref_arm),
		.hsync_lead(hs), .vsync_lead(vs), .frame_start(fs), .ten_field_ref(tf));
	afsut_core #(.POS_W(12)) dut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .video_format_select(fmt),
		.audio_rate_select(rate), .hsync_lead(hs), .vsync_lead(vs), .frame_start(fs), .ten_field_ref(tf),
		.audio_frame_pulse(afp), .aclk_div_restart(rst_p), .user_out(user_out));

	task test_done;
		$display("Checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
			mismatches++;
		end
	endtask

	task wr(input logic [7:0] a, input logic [15:0] v);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask

	task rd(input logic [7:0] a, input logic [15:0] e);
		exp_q.push_back(e);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
	endtask

	always @(posedge mclk) rd_d <= reg_rd;
	always @(negedge mclk) begin
		if (rd_d && exp_q.size() > 0) begin
			chk(reg_rdata, exp_q.pop_front());
		end
	end

	task rise(input logic act);
		int k;
		k = 0;
		@(negedge mclk);
		while (afp === act && k < 20000) begin
			@(negedge mclk);
			k++;
		end
		while (afp !== act && k < 20000) begin
			@(negedge mclk);
			k++;
		end
		if (k >= 20000) begin
			mismatches++;
			test_done();
		end
		t1 = cyc;
		chk({15'h0000, rst_p}, 16'h0001);
		k = 0;
		while (afp === act && k < 100) begin
			@(negedge mclk);
			k++;
		end
		chk(16'(k), 16'h0010);
	endtask

	task gap(input logic act, input int n);
		rise(act);
		t0 = t1;
		rise(act);
		chk(16'(t1 - t0), 16'(n * 96));
	endtask

	task ucount(input int j, input logic [15:0] e);
		int k;
		k = 0;
		repeat (2) @(negedge mclk);
		repeat (96) begin
			@(negedge mclk);
			if (user_out[j] === 1'b1) k++;
		end
		chk(16'(k), e);
	endtask

	task ref_pulse(input int n);
		rise(1'b1);
		t0 = t1;
		@(posedge mclk);
		ref_arm <= 1'b1;
		rise(1'b1);
		@(posedge mclk);
		ref_arm <= 1'b0;
		chk(16'(t1 - t0), 16'(n * 96));
	endtask

	initial begin
		d = 16'($urandom(32'h3aecbe09));
		repeat (2) @(posedge mclk);
		sys_rst <= 1'b0;
		rd(OFS_AUDIO_CTL, 16'h0000);
		rd(OFS_POLARITY, 16'h0000);
		rd(OFS_COMBINE, 16'h0000);
		rd(OFS_DIV_RESET, 16'h0000);
		rd(8'hf0, 16'h0000);
		for (i = 0; i < 16; i++) begin
			d = 16'($urandom) & 16'h0fff;
			wr(OFS_USER_BASE + 8'(i), d);
			rd(OFS_USER_BASE + 8'(i), d);
		end
		wr(OFS_USER_BASE, 16'h0002);
		wr(OFS_USER_BASE + 8'h01, 16'h0005);
		wr(OFS_USER_BASE + 8'h02, 16'h0001);
		wr(OFS_USER_BASE + 8'h03, 16'h0003);
		for (i = 0; i < 4; i++) begin
			wr(OFS_COMBINE, 16'(i));
			ucount(0, tbl[i]);
		end
		wr(OFS_POLARITY, 16'h0002);
		ucount(0, 16'h005a);
		wr(OFS_USER_BASE + 8'h0c, 16'h0002);
		wr(OFS_USER_BASE + 8'h0d, 16'h0005);
		wr(OFS_USER_BASE + 8'h0e, 16'h0001);
		wr(OFS_USER_BASE + 8'h0f, 16'h0003);
		wr(OFS_COMBINE, 16'h0080);
		ucount(3, 16'h0026);
		ucount(0, 16'h005a);
		wr(OFS_DIV_RESET, 16'h0001);
		gap(1'b1, 1);
		@(posedge mclk);
		fmt <= 6'h01;
		wr(OFS_DIV_RESET, 16'h0001);
		gap(1'b1, 5);
		ref_pulse(1);
		@(posedge mclk);
		rate <= RATE_44K1;
		wr(OFS_DIV_RESET, 16'h0001);
		gap(1'b1, 100);
		wr(OFS_FMT_SEL, {5'h00, RATE_32K, 8'h01});
		wr(OFS_AUDIO_CTL, 16'h0003);
		wr(OFS_DIV_RESET, 16'h0001);
		ref_pulse(15);
		wr(OFS_POLARITY, 16'h0003);
		gap(1'b0, 15);
		test_done();
	end

	initial begin
		repeat (60000) @(posedge mclk);
		mismatches++;
		test_done();
	end
endmodule
